// File: rtl/csm_suspend_mod.sv
`timescale 1ns/1ps
`include "csm_consts.svh"
//////////////////////////////////////////////////////////////////////////////
//////////////////////////////////////////////////////////////////////////////
module csm_suspend_mod #(
   parameter int unsigned TICK32_CYC = `CSM_TICK32_CYC,
   parameter int unsigned SECOND_CYC = `CSM_SECOND_CYC
) (
   input  wire logic                  i_clk,
   input  wire logic                  i_rst,
   input  wire logic                  i_cfg_wr,
   input  wire logic [7:0]            i_cfg_addr,
   input  wire logic [7:0]            i_cfg_wdata,
   input  wire logic                  i_cfg_rd,
   output logic      [7:0]            o_cfg_rdata,
   input  wire logic [1:0]            i_mouse_cfg,
   input  wire logic [1:0]            i_idle_enable,
   input  wire csm_pkg::csm_access_type i_access,
   input  wire logic                  i_speedup_event,
   input  wire logic                  i_smi_speedup_active,
   input  wire logic                  i_speedup_disable_read,
   input  wire logic [3:0]            i_general_pin,
   input  wire logic [5:0]            i_status_clear,
   output logic                      o_cpu_suspend_request_n,
   output logic                      o_low_voltage_suspend,
   output logic                      o_serial_activity,
   output logic                      o_keyboard_mouse_activity,
   output logic                      o_system_management_interrupt,
   output csm_pkg::csm_status_type   o_status
);
   logic [7:0]  off_count;
   logic [7:0]  on_count;
   logic [7:0]  cpu_suspend_request_n_cfg;
   logic [7:0]  pin_ctl;
   logic [15:0] disk_count;
   logic [15:0] floppy_count;
   logic [15:0] disk_timer;
   logic [15:0] floppy_timer;
   logic [1:0]  idle_armed;
   logic [11:0] pin_sync;
   logic [3:0]  pin_level;
   logic [3:0]  pin_edge;
   logic [1:0]  idle_expire;
   logic [3:0]  pin_stat;
   logic [1:0]  idle_stat;
   logic        top_stat;
   logic        smi_stopped;
   logic [$clog2(TICK32_CYC)-1:0] tick_div;
   logic [$clog2(SECOND_CYC)-1:0] sec_div;
   logic        tick32;
   logic        tick_sec;
   logic [7:0]  mod_cnt;
   csm_pkg::csm_mod_state_type mod_state;
   csm_pkg::csm_mod_state_type next_mod_state;
   logic [7:0]  next_mod_cnt;
   //////////////////////////////////////////////////////////////////////////////
   // Register writes
   wire wr_off    = i_cfg_wr && (i_cfg_addr == `CSM_OFS_OFF_COUNT);
   wire wr_on     = i_cfg_wr && (i_cfg_addr == `CSM_OFS_ON_COUNT);
   wire wr_cfg    = i_cfg_wr && (i_cfg_addr == `CSM_OFS_CPU_SUSPEND_REQUEST_N_CFG);
   wire wr_pin    = i_cfg_wr && (i_cfg_addr == `CSM_OFS_PIN_CTL2);
   wire wr_dlo    = i_cfg_wr && (i_cfg_addr == `CSM_OFS_DISK_LO);
   wire wr_dhi    = i_cfg_wr && (i_cfg_addr == `CSM_OFS_DISK_HI);
   wire wr_flo    = i_cfg_wr && (i_cfg_addr == `CSM_OFS_FLOPPY_LO);
   wire wr_fhi    = i_cfg_wr && (i_cfg_addr == `CSM_OFS_FLOPPY_HI);
   wire wr_disk   = wr_dlo || wr_dhi;
   wire wr_floppy = wr_flo || wr_fhi;

   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         off_count    <= `CSM_RST_BYTE;
         on_count     <= `CSM_RST_BYTE;
         cpu_suspend_request_n_cfg     <= `CSM_RST_BYTE;
         pin_ctl      <= `CSM_RST_BYTE;
         disk_count   <= `CSM_RST_WORD;
         floppy_count <= `CSM_RST_WORD;
      end else begin
         if (wr_off) off_count <= i_cfg_wdata;
         if (wr_on) on_count <= i_cfg_wdata;
         if (wr_cfg) cpu_suspend_request_n_cfg <= {5'h00, i_cfg_wdata[2:0]}; // Reserved bits stay 0
         if (wr_pin) pin_ctl <= i_cfg_wdata;
         if (wr_dlo) disk_count[7:0] <= i_cfg_wdata;
         if (wr_dhi) disk_count[15:8] <= i_cfg_wdata;
         if (wr_flo) floppy_count[7:0] <= i_cfg_wdata;
         if (wr_fhi) floppy_count[15:8] <= i_cfg_wdata;
      end
   end

   // Read mux, registered so the answer comes one edge after i_cfg_rd
   logic [7:0] rd_mux;
   always_comb begin
      case (i_cfg_addr)
         `CSM_OFS_OFF_COUNT: rd_mux = off_count;
         `CSM_OFS_ON_COUNT:  rd_mux = on_count;
         `CSM_OFS_CPU_SUSPEND_REQUEST_N_CFG:  rd_mux = cpu_suspend_request_n_cfg;
         `CSM_OFS_PIN_CTL2:  rd_mux = pin_ctl;
         `CSM_OFS_DISK_LO:   rd_mux = disk_count[7:0];
         `CSM_OFS_DISK_HI:   rd_mux = disk_count[15:8];
         `CSM_OFS_FLOPPY_LO: rd_mux = floppy_count[7:0];
         `CSM_OFS_FLOPPY_HI: rd_mux = floppy_count[15:8];
         default:            rd_mux = `CSM_RST_BYTE;
      endcase
   end

   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) o_cfg_rdata <= `CSM_RST_BYTE;
      else if (i_cfg_rd) o_cfg_rdata <= rd_mux;
   end
   //////////////////////////////////////////////////////////////////////////////
   // Timebases: one-cycle enables
   wire tick_wrap = (tick_div == ($clog2(TICK32_CYC))'(TICK32_CYC - 1));
   wire sec_wrap  = (sec_div == ($clog2(SECOND_CYC))'(SECOND_CYC - 1));
   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         tick_div <= '0;
         sec_div  <= '0;
         tick32   <= 1'b0;
         tick_sec <= 1'b0;
      end else begin
         tick_div <= tick_wrap ? '0 : tick_div + 1'b1;
         sec_div  <= sec_wrap ? '0 : sec_div + 1'b1;
         tick32   <= tick_wrap;
         tick_sec <= sec_wrap;
      end
   end
   //////////////////////////////////////////////////////////////////////////////
   // Mouse decode
   wire mouse_on     = i_mouse_cfg[`CSM_MOUSE_ON];
   wire mouse_second = i_mouse_cfg[`CSM_MOUSE_PORT];
   wire mouse_hit    = mouse_on && (mouse_second ? i_access.second_serial
                                                 : i_access.first_serial);
   wire serial_hit   = (i_access.first_serial && !(mouse_on && !mouse_second))
                    || (i_access.second_serial && !(mouse_on && mouse_second));
   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         o_serial_activity         <= 1'b0;
         o_keyboard_mouse_activity <= 1'b0;
      end else begin
         o_serial_activity         <= serial_hit;
         o_keyboard_mouse_activity <= mouse_hit;
      end
   end
   //////////////////////////////////////////////////////////////////////////////
   // Pin synchronisers and edge detect
   genvar g;
   generate
      for (g = 0; g < 4; g++) begin : g_pin
         always_ff @(posedge i_clk or posedge i_rst) begin
            if (i_rst) begin
               pin_sync[3*g +: 3] <= 3'h0;
               pin_level[g]       <= 1'b0;
            end else begin
               pin_sync[3*g +: 3] <= {pin_sync[3*g +: 2], i_general_pin[g]};
               // Change accepted once stages two and three agree
               if (pin_sync[3*g+1] == pin_sync[3*g+2]) pin_level[g] <= pin_sync[3*g+2];
            end
         end
         wire agree = (pin_sync[3*g+1] == pin_sync[3*g+2]);
         wire rise  = agree && pin_sync[3*g+2] && !pin_level[g];
         wire fall  = agree && !pin_sync[3*g+2] && pin_level[g];
         // Edge select bits 7..4, enables 3..0
         assign pin_edge[g] = pin_ctl[g] && (pin_ctl[g+4] ? fall : rise);
      end
   endgenerate
   //////////////////////////////////////////////////////////////////////////////
   // Idle timers
   wire disk_en   = i_idle_enable[`CSM_IDLE_DISK_EN];
   wire floppy_en = i_idle_enable[`CSM_IDLE_FLOPPY_EN];
   assign idle_expire[0] = disk_en && idle_armed[0] && tick_sec && (disk_timer <= 16'h0001);
   assign idle_expire[1] = floppy_en && idle_armed[1] && tick_sec && (floppy_timer <= 16'h0001);
   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         disk_timer   <= `CSM_RST_WORD;
         floppy_timer <= `CSM_RST_WORD;
         idle_armed   <= 2'h0;
      end else begin
         if (i_access.disk_data || wr_disk) begin
            disk_timer    <= wr_dlo ? {disk_count[15:8], i_cfg_wdata}
                           : wr_dhi ? {i_cfg_wdata, disk_count[7:0]} : disk_count;
            idle_armed[0] <= 1'b1;
         end else if (idle_expire[0]) begin
            disk_timer    <= `CSM_RST_WORD;
            idle_armed[0] <= 1'b0;
         end else if (disk_en && tick_sec && idle_armed[0]) begin
            disk_timer <= disk_timer - 16'h0001;
         end
         if (i_access.floppy_data || wr_floppy) begin
            floppy_timer  <= wr_flo ? {floppy_count[15:8], i_cfg_wdata}
                           : wr_fhi ? {i_cfg_wdata, floppy_count[7:0]} : floppy_count;
            idle_armed[1] <= 1'b1;
         end else if (idle_expire[1]) begin
            floppy_timer  <= `CSM_RST_WORD;
            idle_armed[1] <= 1'b0;
         end else if (floppy_en && tick_sec && idle_armed[1]) begin
            floppy_timer <= floppy_timer - 16'h0001;
         end
      end
   end
   //////////////////////////////////////////////////////////////////////////////
   // Status: set wins over clear
   wire any_smi = |pin_edge || |idle_expire;
   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         pin_stat  <= 4'h0;
         idle_stat <= 2'h0;
         top_stat  <= 1'b0;
      end else begin
         pin_stat  <= pin_edge | (pin_stat & ~i_status_clear[5:2]);
         idle_stat <= idle_expire | (idle_stat & ~i_status_clear[1:0]);
         top_stat  <= any_smi | (top_stat & ~i_status_clear[0]);
      end
   end

   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         o_status                      <= '0;
         o_system_management_interrupt <= 1'b0;
      end else begin
         o_status                      <= '{pin_stat, idle_stat, top_stat};
         o_system_management_interrupt <= any_smi;
      end
   end
   //////////////////////////////////////////////////////////////////////////////
   // Suspend modulation
   wire mod_en = cpu_suspend_request_n_cfg[`CSM_CFG_MOD_EN];
   // A fresh SYSTEM_MANAGEMENT_INTERRUPT beats a disable read in the same cycle, so no stop is lost
   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) smi_stopped <= 1'b0;
      else if (mod_en && any_smi && cpu_suspend_request_n_cfg[`CSM_CFG_SMI_STOP]) smi_stopped <= 1'b1;
      else if (!mod_en || i_speedup_disable_read) smi_stopped <= 1'b0;
   end
   // Stop mode holds off until the disable read; timer mode uses speedup input
   wire hold_off = smi_stopped || i_speedup_event
                || (!cpu_suspend_request_n_cfg[`CSM_CFG_SMI_STOP] && i_smi_speedup_active);

   always_comb begin
      next_mod_state = mod_state;
      next_mod_cnt   = mod_cnt;
      case (mod_state)
         csm_pkg::MOD_IDLE: begin
            if (mod_en && !hold_off) begin
               next_mod_state = csm_pkg::MOD_OFF;
               next_mod_cnt   = off_count;
            end
         end
         csm_pkg::MOD_OFF: begin
            if (tick32) begin
               if (mod_cnt <= 8'h01) begin
                  next_mod_state = csm_pkg::MOD_ON;
                  next_mod_cnt   = on_count;
               end else next_mod_cnt = mod_cnt - 8'h01;
            end
         end
         csm_pkg::MOD_ON: begin
            if (tick32) begin
               if (mod_cnt <= 8'h01) begin
                  next_mod_state = csm_pkg::MOD_OFF;
                  next_mod_cnt   = off_count;
               end else next_mod_cnt = mod_cnt - 8'h01;
            end
         end
         default: next_mod_state = csm_pkg::MOD_IDLE;
      endcase
      if (!mod_en || hold_off) begin
         next_mod_state = csm_pkg::MOD_IDLE;
         next_mod_cnt   = `CSM_RST_BYTE;
      end
   end

   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         mod_state               <= csm_pkg::MOD_IDLE;
         mod_cnt                 <= `CSM_RST_BYTE;
         o_cpu_suspend_request_n <= 1'b1;
         o_low_voltage_suspend   <= 1'b0;
      end else begin
         mod_state               <= next_mod_state;
         mod_cnt                 <= next_mod_cnt;
         o_cpu_suspend_request_n <= (next_mod_state != csm_pkg::MOD_ON);
         o_low_voltage_suspend   <= cpu_suspend_request_n_cfg[`CSM_CFG_LOW_VOLT];
      end
   end
   //////////////////////////////////////////////////////////////////////////////
   // Checks
   property p_nomod;
      @(posedge i_clk) disable iff (i_rst)
      !mod_en |=> o_cpu_suspend_request_n;
   endproperty
   a_nomod: assert property (p_nomod) else $error("suspend while disabled");

   property p_speedup;
      @(posedge i_clk) disable iff (i_rst)
      i_speedup_event |=> (mod_state == csm_pkg::MOD_IDLE) && o_cpu_suspend_request_n;
   endproperty
   a_speedup: assert property (p_speedup) else $error("speedup ignored");

   property p_pin_stat;
      @(posedge i_clk) disable iff (i_rst)
      pin_edge[3] |=> pin_stat[3];
   endproperty
   a_pin_stat: assert property (p_pin_stat) else $error("pin status lost");

   property p_top;
      @(posedge i_clk) disable iff (i_rst)
      |idle_expire |=> top_stat && o_system_management_interrupt;
   endproperty
   a_top: assert property (p_top) else $error("top status missing");

   property p_once;
      @(posedge i_clk) disable iff (i_rst)
      idle_expire[0] |=> !idle_armed[0];
   endproperty
   a_once: assert property (p_once) else $error("idle smi rearmed");

   property p_lv;
      @(posedge i_clk) disable iff (i_rst)
      $rose(cpu_suspend_request_n_cfg[`CSM_CFG_LOW_VOLT]) |=> o_low_voltage_suspend;
   endproperty
   a_lv: assert property (p_lv) else $error("low voltage bit");

   property p_gate;
      @(posedge i_clk) disable iff (i_rst)
      (pin_ctl[3:0] == 4'h0) && (idle_expire == 2'h0) |=> !o_system_management_interrupt;
   endproperty
   a_gate: assert property (p_gate) else $error("disabled pin fired");

   property p_disk_en;
      @(posedge i_clk) disable iff (i_rst)
      !disk_en && !i_access.disk_data && !wr_disk |=> $stable(disk_timer);
   endproperty
   a_disk_en: assert property (p_disk_en) else $error("disk timer disabled");

   property p_floppy_hold;
      @(posedge i_clk) disable iff (i_rst)
      !floppy_en && !i_access.floppy_data && !wr_floppy |=> $stable(floppy_timer);
   endproperty
   a_floppy_hold: assert property (p_floppy_hold) else $error("floppy timer ran");

   property p_stop;
      @(posedge i_clk) disable iff (i_rst)
      mod_en && cpu_suspend_request_n_cfg[`CSM_CFG_SMI_STOP] && any_smi |=> ##1 o_cpu_suspend_request_n;
   endproperty
   a_stop: assert property (p_stop) else $error("stop mode kept modulating");

   property p_top_out;
      @(posedge i_clk) disable iff (i_rst)
      |pin_edge |=> ##1 o_status.top_status;
   endproperty
   a_top_out: assert property (p_top_out) else $error("top status not shown");

   property p_lv_off;
      @(posedge i_clk) disable iff (i_rst)
      $fell(cpu_suspend_request_n_cfg[`CSM_CFG_LOW_VOLT]) |=> !o_low_voltage_suspend;
   endproperty
   a_lv_off: assert property (p_lv_off) else $error("low voltage stuck");
endmodule // csm_suspend_mod

// File: rtl/csm_consts.svh
`ifndef CSM_CONSTS_SVH
`define CSM_CONSTS_SVH
// Configuration register offsets
`define CSM_OFS_OFF_COUNT   8'h94
`define CSM_OFS_ON_COUNT    8'h95
`define CSM_OFS_CPU_SUSPEND_REQUEST_N_CFG    8'h96
`define CSM_OFS_PIN_CTL2    8'h97
`define CSM_OFS_DISK_LO     8'h98
`define CSM_OFS_DISK_HI     8'h99
`define CSM_OFS_FLOPPY_LO   8'h9a
`define CSM_OFS_FLOPPY_HI   8'h9b
// Configuration bit positions
`define CSM_CFG_MOD_EN      0
`define CSM_CFG_SMI_STOP    1
`define CSM_CFG_LOW_VOLT    2
`define CSM_MOUSE_PORT      0
`define CSM_MOUSE_ON        1
`define CSM_IDLE_DISK_EN    0
`define CSM_IDLE_FLOPPY_EN  1
// Reset values
`define CSM_RST_BYTE        8'h00
`define CSM_RST_WORD        16'h0000
// Timebases at 200 MHz
`define CSM_CLK_NS          5
`define CSM_TICK32_NS       32000
`define CSM_TICK32_CYC      (`CSM_TICK32_NS / `CSM_CLK_NS)
`define CSM_SECOND_NS       1000000000
`define CSM_SECOND_CYC      (`CSM_SECOND_NS / `CSM_CLK_NS)
`endif

// File: rtl/csm_pkg.sv
package csm_pkg;
   typedef struct packed {
      logic       first_serial;
      logic       second_serial;
      logic       disk_data;
      logic       floppy_data;
   } csm_access_type;

   typedef struct packed {
      logic [3:0] pin_status;
      logic [1:0] idle_status;
      logic       top_status;
   } csm_status_type;

   typedef enum logic [2:0] {
      MOD_IDLE = 3'b001,
      MOD_OFF  = 3'b010,
      MOD_ON   = 3'b100
   } csm_mod_state_type;
endpackage

// File: test/csm_cpu_model.sv
`timescale 1ns/1ps
//////////////////////////////////////////////////////////////////////////////
// Processor side of the suspend handshake: measures each phase in clocks
module csm_cpu_model (
   input  wire logic        i_clk,
   input  wire logic        i_rst,
   input  wire logic        i_cpu_suspend_request_n,
   output logic      [15:0] o_low_len,
   output logic      [15:0] o_high_len
);
   logic [15:0] run;
   logic        last;

   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         run <= 16'h0001;
         last <= 1'b1;
         o_low_len <= 16'h0000;
         o_high_len <= 16'h0000;
      end else if (i_cpu_suspend_request_n != last) begin
         // Phase length latched only when it ends, so partial runs never show
         if (last) o_high_len <= run;
         else o_low_len <= run;
         run <= 16'h0001;
         last <= i_cpu_suspend_request_n;
      end else begin
         run <= run + 16'h0001;
      end
   end
endmodule // csm_cpu_model

// File: test/csm_suspend_mod_tb.sv
`timescale 1ns/1ps
module csm_suspend_mod_tb;
   // Short timebases keep the run small
   localparam int T = 4;
   localparam int S = 20;
   logic                    clk = 1'b0;
   logic                    rst = 1'b1;
   logic                    cfg_wr = 1'b0;
   logic                    cfg_rd = 1'b0;
   logic [7:0]              cfg_addr = 8'h00;
   logic [7:0]              cfg_wdata = 8'h00;
   logic [7:0]              cfg_rdata;
   logic [1:0]              mouse_cfg = 2'h0;
   logic [1:0]              idle_en = 2'h0;
   csm_pkg::csm_access_type acc = '0;
   logic                    speedup = 1'b0;
   logic                    spd_act = 1'b0;
   logic                    dis_rd = 1'b0;
   logic [3:0]              pins = 4'h0;
   logic [5:0]              st_clr = 6'h00;
   logic                    cpu_suspend_request_n_n, low_v, ser_act, kbm_act, system_management_interrupt, hit, mouse;
   csm_pkg::csm_status_type status;
   logic [15:0]             low_len, high_len;
   int                      bad_count = 0;
   int                      checks = 0;
   int                      seed = 8;
   int                      cycles = 0;
   int                      exp_reg [int];

   csm_suspend_mod #(.TICK32_CYC(T), .SECOND_CYC(S)) u_dut (
      .i_clk(clk), .i_rst(rst), .i_cfg_wr(cfg_wr), .i_cfg_addr(cfg_addr),
      .i_cfg_wdata(cfg_wdata), .i_cfg_rd(cfg_rd), .o_cfg_rdata(cfg_rdata),
      .i_mouse_cfg(mouse_cfg), .i_idle_enable(idle_en), .i_access(acc),
      .i_speedup_event(speedup), .i_smi_speedup_active(spd_act),
      .i_speedup_disable_read(dis_rd), .i_general_pin(pins), .i_status_clear(st_clr),
      .o_cpu_suspend_request_n(cpu_suspend_request_n_n), .o_low_voltage_suspend(low_v),
      .o_serial_activity(ser_act), .o_keyboard_mouse_activity(kbm_act),
      .o_system_management_interrupt(system_management_interrupt), .o_status(status));
   csm_cpu_model u_cpu (.i_clk(clk), .i_rst(rst), .i_cpu_suspend_request_n(cpu_suspend_request_n_n),
      .o_low_len(low_len), .o_high_len(high_len));

   always #2.5 clk = ~clk;
   always @(posedge clk) begin
      cycles++;
      if (cycles == 20000) begin
         bad_count++;
         summarize();
      end
   end
//////////////////////////////////////////////////////////////////////////////
   task automatic summarize();
      if (bad_count == 0 && checks > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask
   task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
      checks++;
      if (g !== e) begin
         $display("BAD %s expected %h seen %h", nm, e, g);
         bad_count++;
      end
   endtask
   function automatic logic [7:0] exp_of(input int a);
      return (a >= 8'h94 && a <= 8'h9b) ? 8'(exp_reg[a]) : 8'h00;
   endfunction
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(negedge clk);
      cfg_wr = 1'b1;
      cfg_addr = a;
      cfg_wdata = d;
      // Reserved configuration bits never stick
      if (a >= 8'h94 && a <= 8'h9b) exp_reg[a] = (a == 8'h96) ? (d & 8'h07) : d;
      @(negedge clk);
      cfg_wr = 1'b0;
   endtask
   task automatic rd_chk(input logic [7:0] a);
      @(negedge clk);
      cfg_rd = 1'b1;
      cfg_addr = a;
      @(negedge clk);
      cfg_rd = 1'b0;
      chk("cfg_rdata", 16'(exp_of(a)), 16'(cfg_rdata));
   endtask
   // Watches either the interrupt pulse or a low suspend request
   task automatic seen(input int n, input bit want_low, output logic f);
      f = 1'b0;
      repeat (n) begin
         @(negedge clk);
         if (want_low ? (cpu_suspend_request_n_n === 1'b0) : (system_management_interrupt === 1'b1)) f = 1'b1;
      end
   endtask
   task automatic wait_low();
      for (int k = 0; k < 60 && cpu_suspend_request_n_n !== 1'b0; k++) @(negedge clk);
      chk("cpu_suspend_request_n_low", 16'h0000, 16'(cpu_suspend_request_n_n));
   endtask
//////////////////////////////////////////////////////////////////////////////
   initial begin
      for (int a = 8'h94; a <= 8'h9b; a++) exp_reg[a] = 0;
      repeat (16) @(posedge clk);
      @(negedge clk);
      rst = 1'b0;
      for (int a = 8'h94; a <= 8'h9c; a++) rd_chk(8'(a));
      for (int a = 8'h94; a <= 8'h9b; a++) wr(8'(a), 8'($random(seed)));
      wr(8'h50, 8'hff);
      for (int a = 8'h94; a <= 8'h9b; a++) rd_chk(8'(a));
      rd_chk(8'h50);
      wr(8'h96, 8'hfc);
      wr(8'h97, 8'h00);
      rd_chk(8'h96);
      @(negedge clk);
      chk("low_voltage", 16'h0001, 16'(low_v));
      for (int m = 0; m < 4; m++) begin
         for (int p = 0; p < 2; p++) begin
            @(negedge clk);
            mouse_cfg = 2'(m);
            acc.first_serial = (p == 0);
            acc.second_serial = (p == 1);
            @(negedge clk);
            acc = '0;
            mouse = (m >= 2) && ((m % 2) == p);
            chk("kbm_act", 16'(mouse), 16'(kbm_act));
            chk("ser_act", 16'(!mouse), 16'(ser_act));
         end
      end
      for (int i = 0; i < 4; i++) begin
         for (int e = 0; e < 2; e++) begin
            wr(8'h97, 8'h00);
            // Pins stay inputs driven by the bench
            pins[i] = e[0];
            repeat (6) @(negedge clk);
            wr(8'h97, 8'((1 << i) | (e << (i + 4))));
            pins[i] = ~e[0];
            seen(10, 1'b0, hit);
            chk("pin_smi", 16'h0001, 16'(hit));
            chk("pin_status", 16'(1 << i), 16'(status.pin_status));
            chk("top_status", 16'h0001, 16'(status.top_status));
            st_clr = 6'((1 << (i + 2)) | 1);
            @(negedge clk);
            st_clr = 6'h00;
            pins[i] = e[0];
            seen(10, 1'b0, hit);
            chk("wrong_edge", 16'h0000, 16'(hit));
            wr(8'h97, 8'(e << (i + 4)));
            pins[i] = ~e[0];
            seen(10, 1'b0, hit);
            chk("disabled_pin", 16'h0000, 16'(hit));
            chk("pin_status", 16'h0000, 16'(status.pin_status));
         end
      end
      for (int t = 0; t < 2; t++) begin
         wr(8'(8'h99 + 2 * t), 8'h00);
         wr(8'(8'h98 + 2 * t), 8'h03);
         idle_en = 2'(1 << t);
         seen(35, 1'b0, hit);
         chk("idle_early", 16'h0000, 16'(hit));
         seen(30, 1'b0, hit);
         chk("idle_smi", 16'h0001, 16'(hit));
         chk("idle_status", 16'(1 << t), 16'(status.idle_status));
         chk("top_status", 16'h0001, 16'(status.top_status));
         seen(100, 1'b0, hit);
         chk("idle_once", 16'h0000, 16'(hit));
         acc.disk_data = (t == 0);
         acc.floppy_data = (t == 1);
         @(negedge clk);
         acc = '0;
         seen(65, 1'b0, hit);
         chk("reload_smi", 16'h0001, 16'(hit));
         idle_en = 2'h0;
         wr(8'(8'h98 + 2 * t), 8'h02);
         seen(100, 1'b0, hit);
         chk("idle_off", 16'h0000, 16'(hit));
         st_clr = 6'h03;
         @(negedge clk);
         st_clr = 6'h00;
      end
      wr(8'h97, 8'h00);
      wr(8'h94, 8'h02);
      wr(8'h95, 8'h03);
      wr(8'h96, 8'h01);
      repeat (120) @(negedge clk);
      chk("on_len", 16'(3 * T), low_len);
      chk("off_len", 16'(2 * T), high_len);
      wait_low();
      speedup = 1'b1;
      @(negedge clk);
      speedup = 1'b0;
      @(negedge clk);
      chk("speedup_restart", 16'h0001, 16'(cpu_suspend_request_n_n));
      // Timer mode: a running speedup timer holds the request off
      wait_low();
      spd_act = 1'b1;
      seen(40, 1'b1, hit);
      chk("timer_hold", 16'h0000, 16'(hit));
      spd_act = 1'b0;
      seen(40, 1'b1, hit);
      chk("timer_release", 16'h0001, 16'(hit));
      wr(8'h96, 8'h03);
      wr(8'h97, 8'h01);
      pins[0] = 1'b0;
      repeat (6) @(negedge clk);
      wait_low();
      pins[0] = 1'b1;
      seen(10, 1'b0, hit);
      chk("stop_smi", 16'h0001, 16'(hit));
      seen(80, 1'b1, hit);
      chk("stop_hold", 16'h0000, 16'(hit));
      dis_rd = 1'b1;
      @(negedge clk);
      dis_rd = 1'b0;
      seen(40, 1'b1, hit);
      chk("stop_release", 16'h0001, 16'(hit));
      wr(8'h96, 8'h00);
      repeat (5) @(negedge clk);
      seen(80, 1'b1, hit);
      chk("mod_off", 16'h0000, 16'(hit));
      chk("low_voltage", 16'h0000, 16'(low_v));
      summarize();
   end
endmodule // csm_suspend_mod_tb
